//--- smws_defines.svh
// Constants for the sleep mode wake sequencer: timing counts and field sizes.
// Assumes a 25 MHz system clock; included by the package and by the sequencer.
//
// How it works
// - Power-save instruction with mode operand selects sleep or idle; controller enters it.
// - Idle halts the CPU but keeps the system clock and peripherals running.
// - Sleep stops the system clock, on-chip oscillator and system-clocked peripherals.
// - Fail-safe clock monitor is inactive while asleep.
// - Low-power RC clock keeps running in sleep when the watchdog is enabled.
// - Enabled watchdog is cleared just before sleep is entered.
// - Sleep ends on an enabled interrupt, any reset, or a watchdog time-out.
// - Wake restarts the clock source that was active at sleep entry.
// - Every sleep wake holds internal system reset for the power-on delay.
// - Crystal or PLL clocks get start-up count and/or lock time before delivery.
// - No oscillator delay for kept low-freq crystal, RC or external sources.
// - Start-up timer counts 1024 oscillator periods before releasing the clock.
// - PLL in the path gets the nominal lock time before its output is used.
// - Crystal/PLL with oscillator off gets the clock-monitor delay after power-on delay.
// - Clock monitor starts watching only after the clock-monitor delay.
// - Clock unstable at delay end with monitor on: trap, switch to fast RC.
// - Clock unstable with monitor off: withhold execution until clock is stable.
// - Priority-zero interrupts never wake; enabled priority one or higher do.
// - Source priority at most CPU priority resumes; higher takes the exception.
// - Interrupt wake from sleep sets the sleep status flag.
// - Non-power-on reset waking from sleep sets sleep flag; power-on reset clears it.
// - Watchdog expiry in sleep wakes without reset, sets sleep and watchdog flags.
// - Watchdog time-out in run forces reset; in sleep or idle only wakes.
`ifndef SMWS_DEFINES_SVH
`define SMWS_DEFINES_SVH

`define SMWS_CLK_MHZ       25
`define SMWS_TMR_W         12
`define SMWS_PRIO_W        3
`define SMWS_PRIO_NONE     3'h0

// Times in ns as printed; least times round up to whole cycles
`define SMWS_T_POR_NS      10000
`define SMWS_T_LOCK_NS     20000
`define SMWS_T_FAIL_SAFE_CLOCK_MONITOR_NS     100000
`define SMWS_CYC_MIN(ns)   ((((ns) * `SMWS_CLK_MHZ) + 999) / 1000)
`define SMWS_POR_CYC       `SMWS_CYC_MIN(`SMWS_T_POR_NS)
`define SMWS_LOCK_CYC      `SMWS_CYC_MIN(`SMWS_T_LOCK_NS)
`define SMWS_FAIL_SAFE_CLOCK_MONITOR_CYC      `SMWS_CYC_MIN(`SMWS_T_FAIL_SAFE_CLOCK_MONITOR_NS)
`define SMWS_OST_PERIODS   1024

`endif

//--- smws_pkg.sv
// Types shared by the sleep mode wake sequencer and its delay timer.
// Assumes smws_defines.svh is on the include path.
`include "smws_defines.svh"

package smws_pkg;

  typedef enum logic [2:0] {
    SRC_EXT_CLOCK, SRC_EXT_RC, SRC_STD_XTAL, SRC_HS_XTAL,
    SRC_LS_XTAL, SRC_LF_XTAL, SRC_FAST_RC, SRC_LOW_PWR_RC
  } smws_src_e;

  typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_SLEEP, ST_POR, ST_DLY, ST_STABLE} smws_state_e;

  typedef enum logic [1:0] {WK_NONE, WK_RESUME, WK_ISR} smws_wake_e;

  typedef struct packed {
    logic [`SMWS_TMR_W-1:0] cnt;
    logic                   busy;
  } smws_tmr_s;

  typedef struct packed {
    smws_state_e st;
    smws_src_e   src;
    logic        pll;
    logic        lp_kept;
    logic        need_dly;
    logic        lock_go;
    logic        on_frc;
    smws_wake_e  action;
    logic        sleep_flag;
    logic        idle_flag;
    logic        watchdog_timeout_flag_flag;
    logic        resume;
    logic        take_isr;
    logic        trap;
    logic        wdt_rst;
  } smws_seq_s;

  function automatic logic smws_is_crystal(smws_src_e s);
    return (s == SRC_STD_XTAL) || (s == SRC_HS_XTAL) || (s == SRC_LS_XTAL) ||
           (s == SRC_LF_XTAL);
  endfunction

endpackage

//--- smws_delay_timer.sv
// Down-counting delay timer, busy for 'load' counted ticks after start.
// Assumes start is a one-cycle pulse; tick is synchronous to clock.
`timescale 1ns/100ps
`include "smws_defines.svh"

module smws_delay_timer (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   nrst,
  // Control
  input  wire logic                   start,
  input  wire logic                   tick,
  input  wire logic [`SMWS_TMR_W-1:0] load,
  // Status
  output logic                        busy
);
  import smws_pkg::*;

  smws_tmr_s r;
  smws_tmr_s next_r;

  always_comb begin
    next_r = r;
    if (start) begin
      next_r.cnt  = load;
      next_r.busy = (load != '0);
    end else if (r.busy && tick) begin
      next_r.cnt = r.cnt - `SMWS_TMR_W'(1);
      if (r.cnt == `SMWS_TMR_W'(1)) begin
        next_r.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.busy;

endmodule // smws_delay_timer

//--- smws_sequencer.sv
// Sleep/idle entry and wake-up sequencer for the CPU power-save instruction.
// Assumes all inputs synchronous to clock; nrst is the power-on reset and
// osc_tick pulses once per period of the restarting oscillator.
`timescale 1ns/100ps
`include "smws_defines.svh"

module smws_sequencer (
  // Clock and power-on reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Power-save instruction from the CPU
  input  wire logic                    power_save_instruction,
  input  wire logic                    sleep_sel,
  // Clock configuration
  input  wire smws_pkg::smws_src_e     clk_src,
  input  wire logic                    pll_en,
  input  wire logic                    lp_run_in_sleep,
  input  wire logic                    osc_tick,
  input  wire logic                    osc_stable,
  input  wire logic                    fail_safe_clock_monitor_en,
  input  wire logic                    frc_release,
  // Wake sources
  input  wire logic                    src_irq_valid,
  input  wire logic                    interrupt_enable_bit,
  input  wire logic [`SMWS_PRIO_W-1:0] src_irq_prio,
  input  wire logic [`SMWS_PRIO_W-1:0] cpu_prio,
  input  wire logic                    other_reset,
  input  wire logic                    wdt_en,
  input  wire logic                    wdt_timeout,
  // Software flag clears
  input  wire logic                    sleep_flag_clr,
  input  wire logic                    idle_flag_clr,
  input  wire logic                    watchdog_timeout_flag_flag_clr,
  // Clock and power control
  output logic                         cpu_halt,
  output logic                         sys_clk_en,
  output logic                         periph_clk_en,
  output logic                         osc_en,
  output logic                         low_power_rc_osc_en,
  output logic                         fail_safe_clock_monitor_active,
  output smws_pkg::smws_src_e          osc_select,
  output logic                         internal_system_reset,
  // Events
  output logic                         wdt_clear,
  output logic                         wdt_reset_req,
  output logic                         wake_resume,
  output logic                         wake_take_isr,
  output logic                         clk_fail_trap,
  // Wake cause flags
  output logic                         sleep_flag,
  output logic                         idle_flag,
  output logic                         watchdog_timeout_flag
);
  import smws_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and delay timers

  smws_seq_s r;
  smws_seq_s next_r;

  logic por_start;
  logic fail_safe_clock_monitor_start;
  logic ost_start;
  logic lock_start;
  logic por_busy;
  logic fail_safe_clock_monitor_busy;
  logic ost_busy;
  logic lock_busy;
  logic wake_irq;
  logic wake_wdt;
  logic clk_ready;
  logic in_wait;
  smws_wake_e irq_action;

  smws_delay_timer u_por (
    .clock (clock),
    .nrst  (nrst),
    .start (por_start),
    .tick  (1'b1),
    // Leaving the hold state costs a cycle, so count one less
    .load  (`SMWS_TMR_W'(`SMWS_POR_CYC - 1)),
    .busy  (por_busy)
  );

  smws_delay_timer u_fail_safe_clock_monitor (
    .clock (clock),
    .nrst  (nrst),
    .start (fail_safe_clock_monitor_start),
    .tick  (1'b1),
    .load  (`SMWS_TMR_W'(`SMWS_FAIL_SAFE_CLOCK_MONITOR_CYC)),
    .busy  (fail_safe_clock_monitor_busy)
  );

  // Counts oscillator periods, not system cycles
  smws_delay_timer u_ost (
    .clock (clock),
    .nrst  (nrst),
    .start (ost_start),
    .tick  (osc_tick),
    .load  (`SMWS_TMR_W'(`SMWS_OST_PERIODS)),
    .busy  (ost_busy)
  );

  smws_delay_timer u_lock (
    .clock (clock),
    .nrst  (nrst),
    .start (lock_start),
    .tick  (1'b1),
    .load  (`SMWS_TMR_W'(`SMWS_LOCK_CYC)),
    .busy  (lock_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wake decode

  assign wake_irq   = src_irq_valid && interrupt_enable_bit &&
                      (src_irq_prio != `SMWS_PRIO_NONE);
  assign wake_wdt   = wdt_timeout && wdt_en;
  assign irq_action = (src_irq_prio <= cpu_prio) ? WK_RESUME : WK_ISR;
  // Oscillator delays done; lock only counts once the start-up count ends
  assign clk_ready  = !ost_busy && !lock_busy && (!r.pll || r.lock_go);
  assign in_wait    = (r.st == ST_POR) || (r.st == ST_DLY) || (r.st == ST_STABLE);

  // Release to run and fire the deferred resume or exception pulse
  function automatic smws_seq_s smws_finish(smws_seq_s x);
    smws_seq_s y;
    y          = x;
    y.st       = ST_RUN;
    y.resume   = (x.action == WK_RESUME);
    y.take_isr = (x.action == WK_ISR);
    return y;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_r          = r;
    next_r.resume   = 1'b0;
    next_r.take_isr = 1'b0;
    next_r.trap     = 1'b0;
    next_r.wdt_rst  = 1'b0;
    por_start       = 1'b0;
    fail_safe_clock_monitor_start      = 1'b0;
    ost_start       = 1'b0;
    lock_start      = 1'b0;
    wdt_clear       = 1'b0;
    if (frc_release) begin
      next_r.on_frc = 1'b0;
    end
    // Clears go first so a set later in this process wins
    next_r.sleep_flag = r.sleep_flag && !sleep_flag_clr;
    next_r.idle_flag  = r.idle_flag && !idle_flag_clr;
    next_r.watchdog_timeout_flag_flag  = r.watchdog_timeout_flag_flag && !watchdog_timeout_flag_flag_clr;
    case (r.st)
      ST_RUN: begin
        if (!r.on_frc) begin
          next_r.src = clk_src;
          next_r.pll = pll_en;
        end
        if (other_reset) begin
          next_r.st       = ST_POR;
          next_r.need_dly = 1'b0;
          next_r.action   = WK_NONE;
          next_r.on_frc   = 1'b0;
          por_start       = 1'b1;
        end else if (wake_wdt) begin
          next_r.wdt_rst   = 1'b1;
          next_r.watchdog_timeout_flag_flag = 1'b1;
        end else if (power_save_instruction) begin
          wdt_clear      = wdt_en;
          next_r.lp_kept = lp_run_in_sleep;
          next_r.st      = sleep_sel ? ST_SLEEP : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (other_reset) begin
          next_r.idle_flag = 1'b1;
          next_r.st        = ST_POR;
          next_r.need_dly  = 1'b0;
          next_r.action    = WK_NONE;
          por_start        = 1'b1;
        end else if (wake_wdt) begin
          next_r.idle_flag = 1'b1;
          next_r.watchdog_timeout_flag_flag = 1'b1;
          next_r.resume    = 1'b1;
          next_r.st        = ST_RUN;
        end else if (wake_irq) begin
          next_r.idle_flag = 1'b1;
          next_r.resume    = (irq_action == WK_RESUME);
          next_r.take_isr  = (irq_action == WK_ISR);
          next_r.st        = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (other_reset || wake_wdt || wake_irq) begin
          next_r.sleep_flag = 1'b1;
          next_r.st         = ST_POR;
          por_start         = 1'b1;
          // Without the PLL, kept low-freq crystal and RC/external sources need no delay
          next_r.need_dly   = r.pll || (smws_is_crystal(r.src) &&
                              !((r.src == SRC_LF_XTAL) && r.lp_kept));
          if (other_reset) begin
            next_r.action = WK_NONE;
          end else if (wake_wdt) begin
            next_r.watchdog_timeout_flag_flag = 1'b1;
            next_r.action    = WK_RESUME;
          end else begin
            next_r.action = irq_action;
          end
        end
      end
      ST_POR: begin
        if (!por_busy) begin
          if (r.need_dly) begin
            next_r.st      = ST_DLY;
            next_r.lock_go = 1'b0;
            fail_safe_clock_monitor_start     = 1'b1;
            ost_start      = smws_is_crystal(r.src);
          end else begin
            next_r = smws_finish(next_r);
          end
        end
      end
      ST_DLY: begin
        if (r.pll && !r.lock_go && !ost_busy) begin
          lock_start     = 1'b1;
          next_r.lock_go = 1'b1;
        end
        if (!fail_safe_clock_monitor_busy) begin
          if (clk_ready && osc_stable) begin
            next_r = smws_finish(next_r);
          end else if (fail_safe_clock_monitor_en) begin
            next_r        = smws_finish(next_r);
            next_r.trap   = 1'b1;
            next_r.on_frc = 1'b1;
            next_r.src    = SRC_FAST_RC;
          end else begin
            next_r.st = ST_STABLE;
          end
        end
      end
      ST_STABLE: begin
        if (clk_ready && osc_stable) begin
          next_r = smws_finish(next_r);
        end
      end
      default: begin
        next_r.st = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r        <= '0;
      r.st     <= ST_RUN;
      r.src    <= SRC_FAST_RC;
      r.action <= WK_NONE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cpu_halt              = (r.st != ST_RUN);
  assign sys_clk_en            = (r.st == ST_RUN) || (r.st == ST_IDLE) ||
                                 (in_wait && (!r.need_dly || (clk_ready && osc_stable)));
  assign periph_clk_en         = sys_clk_en;
  assign osc_en                = (r.st != ST_SLEEP) ||
                                 ((r.src == SRC_LF_XTAL) && r.lp_kept);
  assign low_power_rc_osc_en               = wdt_en || (fail_safe_clock_monitor_en && (r.st != ST_SLEEP));
  assign fail_safe_clock_monitor_active           = fail_safe_clock_monitor_en && ((r.st == ST_RUN) || (r.st == ST_IDLE));
  assign osc_select            = r.src;
  assign internal_system_reset = (r.st == ST_POR);
  assign wdt_reset_req         = r.wdt_rst;
  assign wake_resume           = r.resume;
  assign wake_take_isr         = r.take_isr;
  assign clk_fail_trap         = r.trap;
  assign sleep_flag            = r.sleep_flag;
  assign idle_flag             = r.idle_flag;
  assign watchdog_timeout_flag = r.watchdog_timeout_flag_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int POR_LEN = `SMWS_POR_CYC;

  logic [`SMWS_TMR_W-1:0] hold_cnt;

  always_ff @(posedge clock) begin
    if (!nrst || !internal_system_reset) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + `SMWS_TMR_W'(1);
    end
  end

  logic irq_slept;

  // Marks an interrupt wake from sleep until the core runs again
  always_ff @(posedge clock) begin
    if (!nrst || (r.st == ST_RUN)) begin
      irq_slept <= 1'b0;
    end else if ((r.st == ST_SLEEP) && wake_irq) begin
      irq_slept <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sleep_clk_off_a: assert property (
    (r.st == ST_SLEEP) |-> (!sys_clk_en && !periph_clk_en && !cpu_halt == 1'b0))
    else $error("clock or peripherals running in sleep");

  fail_safe_clock_monitor_sleep_off_a: assert property (
    (r.st == ST_SLEEP) || (r.st == ST_DLY) |-> !fail_safe_clock_monitor_active)
    else $error("clock monitor active in sleep or before its delay");

  low_power_rc_osc_sleep_a: assert property (
    (r.st == ST_SLEEP) && wdt_en |-> low_power_rc_osc_en)
    else $error("low-power rc stopped in sleep with watchdog on");

  wdt_clear_entry_a: assert property (
    (r.st == ST_RUN) && power_save_instruction && sleep_sel && wdt_en && !other_reset &&
    !wake_wdt |-> wdt_clear ##1 (r.st == ST_SLEEP))
    else $error("watchdog not cleared on sleep entry");

  por_hold_a: assert property (
    $fell(internal_system_reset) |-> (hold_cnt == POR_LEN[`SMWS_TMR_W-1:0]))
    else $error("system reset not held for the power-on delay");

  prio_zero_a: assert property (
    (r.st == ST_SLEEP) && !other_reset && !wake_wdt && (src_irq_prio == `SMWS_PRIO_NONE)
    |=> (r.st == ST_SLEEP))
    else $error("priority zero interrupt woke the device");

  irq_wake_flag_a: assert property (
    (r.st == ST_SLEEP) && wake_irq |=> internal_system_reset && sleep_flag)
    else $error("interrupt wake from sleep missed");

  wdt_sleep_wake_a: assert property (
    (r.st == ST_SLEEP) && wake_wdt && !other_reset |=> !wdt_reset_req &&
    watchdog_timeout_flag && sleep_flag)
    else $error("watchdog in sleep did not wake cleanly");

  wdt_run_reset_a: assert property (
    (r.st == ST_RUN) && wake_wdt && !other_reset |=> wdt_reset_req && watchdog_timeout_flag)
    else $error("watchdog in run did not request reset");

  trap_frc_a: assert property (
    clk_fail_trap |-> (osc_select == SRC_FAST_RC) && !cpu_halt && !fail_safe_clock_monitor_busy)
    else $error("clock trap without switch to fast rc");

  dly_order_a: assert property (
    (r.st == ST_DLY) |-> !internal_system_reset && cpu_halt)
    else $error("execution released before delays ended");

  sleep_irq_c: cover property (irq_slept && wake_take_isr);
  idle_wdt_c: cover property ((r.st == ST_IDLE) && wake_wdt ##1 wake_resume);
  trap_c: cover property (clk_fail_trap);
  stable_wait_c: cover property ((r.st == ST_STABLE) ##1 (r.st == ST_RUN));

endmodule // smws_sequencer

//--- smws_cpu_model.sv
// CPU core partner model: issues the power-save instruction with its operand.
// Assumes the bench calls issue and retire just after a rising clock edge.
`timescale 1ns/100ps

module smws_cpu_model (
  // Core state
  input  wire logic cpu_halt,
  // Power-save request
  output logic      power_save_instruction,
  output logic      sleep_sel
);
  initial begin
    power_save_instruction = 1'b0;
    sleep_sel              = 1'b0;
  end

  // A halted core cannot execute anything
  task issue(input logic sel);
    if (cpu_halt === 1'b0) begin
      power_save_instruction = 1'b1;
      sleep_sel              = sel;
    end
  endtask

  task retire();
    power_save_instruction = 1'b0;
  endtask
endmodule // smws_cpu_model

//--- tb_top.sv
// Self-checking bench for the sleep mode wake sequencer.
// Assumes smws_pkg is compiled first and smws_defines.svh is on the include path.
`timescale 1ns/100ps
`include "smws_defines.svh"

module tb_top;
  import smws_pkg::*;
  logic clock, nrst, psi, ssel, pll_en, lp_run_in_sleep, osc_tick, osc_stable, fail_safe_clock_monitor_en;
  logic frc_release, src_irq_valid, interrupt_enable_bit, other_reset, wdt_en, wdt_timeout;
  logic sleep_flag_clr, idle_flag_clr, watchdog_timeout_flag_flag_clr;
  logic [2:0] src_irq_prio, cpu_prio;
  smws_src_e clk_src, osc_select;
  logic cpu_halt, sys_clk_en, periph_clk_en, osc_en, low_power_rc_osc_en, fail_safe_clock_monitor_active, internal_system_reset;
  logic wdt_clear, wdt_reset_req, wake_resume, wake_take_isr, clk_fail_trap;
  logic sleep_flag, idle_flag, watchdog_timeout_flag;
  logic [6:0] q[$];
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'h3424b50d;

  smws_cpu_model u_smws_cpu_model (.cpu_halt(cpu_halt), .power_save_instruction(psi),
    .sleep_sel(ssel));
  smws_sequencer u_smws_sequencer (.clock(clock), .nrst(nrst), .power_save_instruction(psi),
    .sleep_sel(ssel), .clk_src(clk_src), .pll_en(pll_en), .lp_run_in_sleep(lp_run_in_sleep),
    .osc_tick(osc_tick), .osc_stable(osc_stable), .fail_safe_clock_monitor_en(fail_safe_clock_monitor_en),
    .frc_release(frc_release), .src_irq_valid(src_irq_valid),
    .interrupt_enable_bit(interrupt_enable_bit), .src_irq_prio(src_irq_prio),
    .cpu_prio(cpu_prio), .other_reset(other_reset), .wdt_en(wdt_en),
    .wdt_timeout(wdt_timeout), .sleep_flag_clr(sleep_flag_clr),
    .idle_flag_clr(idle_flag_clr), .watchdog_timeout_flag_flag_clr(watchdog_timeout_flag_flag_clr), .cpu_halt(cpu_halt),
    .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .low_power_rc_osc_en(low_power_rc_osc_en), .fail_safe_clock_monitor_active(fail_safe_clock_monitor_active), .osc_select(osc_select),
    .internal_system_reset(internal_system_reset), .wdt_clear(wdt_clear),
    .wdt_reset_req(wdt_reset_req), .wake_resume(wake_resume),
    .wake_take_isr(wake_take_isr), .clk_fail_trap(clk_fail_trap),
    .sleep_flag(sleep_flag), .idle_flag(idle_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick_n(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Clears also drop any forced fast-RC selection left by a trap
  task clr_flags();
    {sleep_flag_clr, idle_flag_clr, watchdog_timeout_flag_flag_clr, frc_release} = 4'hF;
    tick_n(1);
    {sleep_flag_clr, idle_flag_clr, watchdog_timeout_flag_flag_clr, frc_release} = 4'h0;
    tick_n(1);
  endtask

  // Wake inputs are one-shot; they drop after the edge that took them
  task wake_wait(output int n, output int rc);
    n = 0;
    rc = 0;
    while (cpu_halt !== 1'b0 && n < 5000) begin
      tick_n(1);
      n++;
      if (n == 1) {other_reset, wdt_timeout, src_irq_valid} = 3'h0;
      if (internal_system_reset === 1'b1) rc++;
    end
  endtask

  // wk: 0 interrupt, 1 watchdog, 2 other reset
  task sleep_case(input smws_src_e s, input logic pll, kept, stab, fsc, input int wk, lo, hi);
    int n, rc;
    logic [6:0] note;
    clk_src = s;
    pll_en = pll;
    lp_run_in_sleep = kept;
    osc_stable = stab;
    fail_safe_clock_monitor_en = fsc;
    wdt_en = (wk == 1);
    clr_flags();
    u_smws_cpu_model.issue(1'b1);
    #1;
    chk("wdt_clear", wdt_clear, wdt_en);
    tick_n(1);
    u_smws_cpu_model.retire();
    chk("sleep gates", {cpu_halt, sys_clk_en, periph_clk_en, fail_safe_clock_monitor_active}, 4'h8);
    chk("osc_en", osc_en, (s == SRC_LF_XTAL) && kept);
    if (wk == 1) chk("low_power_rc_osc_en", low_power_rc_osc_en, 1'b1);
    {src_irq_valid, interrupt_enable_bit, src_irq_prio, cpu_prio} = {2'b11, 3'h0, 3'h3};
    tick_n(5);
    chk("prio zero", {cpu_halt, internal_system_reset}, 2'b10);
    note = (wk == 1) ? 7'h45 : 7'h44;
    if (!stab && fsc) note[4] = 1'b1;
    // Fast RC case wakes above the core's level and takes the exception
    if (s == SRC_FAST_RC) note = 7'h24;
    if (wk != 2) q.push_back(note);
    if (wk == 0) src_irq_prio = (s == SRC_FAST_RC) ? 3'h5 : 3'h2;
    else src_irq_valid = 1'b0;
    wdt_timeout = (wk == 1);
    other_reset = (wk == 2);
    if (!stab && !fsc) fork
      begin
        tick_n(3000);
        osc_stable = 1'b1;
      end
    join_none
    wake_wait(n, rc);
    chk("reset hold", rc, `SMWS_POR_CYC);
    chk("wake time", (n >= lo) && (n <= hi), 1'b1);
    chk("sleep_flag", sleep_flag, 1'b1);
    chk("osc_select", osc_select, (!stab && fsc) ? SRC_FAST_RC : s);
    chk("fail_safe_clock_monitor_active", fail_safe_clock_monitor_active, fsc);
    tick_n(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Every wake or watchdog pulse consumes the oldest note; looked at mid-cycle
  always @(negedge clock) begin
    if (nrst === 1'b1 && (wake_resume | wake_take_isr | clk_fail_trap | wdt_reset_req) === 1'b1)
      begin
      if (q.size() == 0) chk("unexpected event", 1'b1, 1'b0);
      else chk("event", {wake_resume, wake_take_isr, clk_fail_trap, wdt_reset_req, sleep_flag,
                         idle_flag, watchdog_timeout_flag}, q.pop_front());
    end
  end

  initial begin
    #1600000;
    fail_count++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] p, c;
    int dly;
    {nrst, pll_en, lp_run_in_sleep, fail_safe_clock_monitor_en, frc_release, src_irq_valid} = 6'h0;
    {interrupt_enable_bit, other_reset, wdt_en, wdt_timeout} = 4'h0;
    {sleep_flag_clr, idle_flag_clr, watchdog_timeout_flag_flag_clr, src_irq_prio, cpu_prio} = 9'h0;
    {osc_tick, osc_stable} = 2'b11;
    clk_src = SRC_EXT_CLOCK;
    dly = `SMWS_POR_CYC + `SMWS_FAIL_SAFE_CLOCK_MONITOR_CYC + 2;
    tick_n(6);
    nrst = 1'b1;
    tick_n(1);
    chk("after reset", {cpu_halt, sys_clk_en, internal_system_reset, sleep_flag}, 4'h4);
    // Idle: disabled source ignored, then random priorities
    clr_flags();
    u_smws_cpu_model.issue(1'b0);
    tick_n(1);
    u_smws_cpu_model.retire();
    {src_irq_valid, interrupt_enable_bit, src_irq_prio} = {2'b10, 3'h7};
    tick_n(3);
    chk("disabled irq", cpu_halt, 1'b1);
    for (int i = 0; i < 6; i++) begin
      p = 3'((($random(seed) & 32'h7FFF) % 7) + 1);
      c = 3'($random(seed));
      clr_flags();
      cpu_prio = c;
      u_smws_cpu_model.issue(1'b0);
      tick_n(1);
      u_smws_cpu_model.retire();
      chk("idle gates", {cpu_halt, sys_clk_en, periph_clk_en}, 3'h7);
      {src_irq_valid, interrupt_enable_bit, src_irq_prio} = {2'b11, p};
      q.push_back({p <= c, p > c, 5'h02});
      tick_n(1);
      src_irq_valid = 1'b0;
      tick_n(1);
      chk("idle wake", {cpu_halt, idle_flag}, 2'b01);
    end
    // Watchdog expiry while running
    clr_flags();
    wdt_en = 1'b1;
    q.push_back(7'h09);
    wdt_timeout = 1'b1;
    tick_n(1);
    wdt_timeout = 1'b0;
    tick_n(3);
    // Sleep with each delay class
    sleep_case(SRC_EXT_CLOCK, 0, 0, 1, 0, 0, 251, 251);
    sleep_case(SRC_FAST_RC, 0, 0, 1, 0, 0, 251, 251);
    sleep_case(SRC_LF_XTAL, 0, 1, 1, 0, 1, 251, 251);
    sleep_case(SRC_STD_XTAL, 0, 0, 1, 1, 0, dly, dly + 2);
    sleep_case(SRC_EXT_CLOCK, 1, 0, 1, 0, 1, dly, dly + 2);
    sleep_case(SRC_HS_XTAL, 0, 0, 0, 1, 0, dly, dly + 2);
    sleep_case(SRC_LS_XTAL, 0, 0, 0, 0, 0, 3001, 3010);
    sleep_case(SRC_EXT_RC, 0, 0, 1, 0, 2, 251, 251);
    chk("notes left", q.size(), 0);
    nrst = 1'b0;
    tick_n(2);
    chk("por clears", sleep_flag, 1'b0);
    end_of_test();
  end
endmodule // tb_top
